// ### core/eds_pkg.sv
// Purpose: Shared constants for the extended data space paging block
// Assumes: 16-bit base effective addresses, 9-bit page values
// Notes: Extended address is page value above the 15-bit window offset
package ext_space_pkg;
    localparam int BASE_W = 16;
    localparam int OFFSET_W = 15;
    localparam int PAGE_W = 9;
    localparam int EXT_W = PAGE_W + OFFSET_W;
    localparam int UPPER_BIT = 15;
    localparam int SEL_READ = 0;
    localparam int SEL_WRITE = 1;
    localparam int PAGE_COUNT = 2;
    localparam logic [PAGE_W-1:0] PAGE_ZERO = 9'h000;
    localparam logic [PAGE_W-1:0] PAGE_ONE = 9'h001;
    localparam logic [PAGE_W-1:0] PAGE_TWO = 9'h002;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 9'h001;
    localparam logic [EXT_W-1:0] PAGE1_BASE = 24'h008000;
    localparam logic [EXT_W-1:0] PAGE1_TOP = 24'h00FFFF;
    localparam logic [EXT_W-1:0] PAGE2_BASE = 24'h010000;
    localparam logic [EXT_W-1:0] PAGE2_TOP = 24'h017FFF;
endpackage

// ### core/extended_data_space_paging.sv
// Purpose: Map base effective addresses into the extended data space
// Assumes: Requests and page writes come from logic on clk
// Notes: An access uses the page value held before a same-cycle write
//        Zero page writes are dropped, so the trap path stays dormant
//        ext_addr moves every cycle; only valid or trap qualify it
//
// Summary of operation
// - Lower half addresses always pass directly
// - Bit 15 clear means page zero
// - Upper window never reaches page zero
// - Both page registers reset to one
// - Upper access with zero page traps
// - Writing zero leaves page register unchanged
// - Other pages only via upper window
// - Page one maps to 0x008000-0x00FFFF
// - Page two maps 0x010000-0x017FFF, onward
`timescale 1ns/100ps
`default_nettype none
module extended_data_space_paging
    import ext_space_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [BASE_W-1:0] effective_addr,
    input wire logic page_wr_en,
    input wire logic page_wr_sel,
    input wire logic [PAGE_W-1:0] page_wr_data,
    output logic ext_valid,
    output logic ext_write,
    output logic [EXT_W-1:0] ext_addr,
    output logic addr_error_trap,
    output logic [PAGE_W-1:0] read_page_select,
    output logic [PAGE_W-1:0] write_page_select
);
    // ************************************************************
    // Page registers
    // ************************************************************
    page_reg_if pg[PAGE_COUNT] ();

    // One register for each access direction
    genvar i;
    generate
        for (i = 0; i < PAGE_COUNT; i++)
        begin : gen_page
            // Steer software write to the selected register
            assign pg[i].wr_en = page_wr_en && (page_wr_sel == 1'(i));
            assign pg[i].wr_data = page_wr_data;
            page_register u_page (
                .clk(clk),
                .rstn(rstn),
                .port(pg[i])
            );
        end
    endgenerate

    // Register outputs straight from the page flip-flops
    assign read_page_select = pg[SEL_READ].page;
    assign write_page_select = pg[SEL_WRITE].page;

    // ************************************************************
    // Address translation
    // ************************************************************
    // Window flag, chosen page and its zero test
    logic upper;
    logic [PAGE_W-1:0] sel_page;
    logic zero_page;

    // Pick the page by direction of the access
    assign upper = effective_addr[UPPER_BIT];
    assign sel_page = req_write ? write_page_select : read_page_select;
    assign zero_page = (sel_page == PAGE_ZERO);

    // Completion strobe, withheld for a zero page upper access
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ext_valid <= 1'b0;
        end
        else
        begin
            ext_valid <= req_valid && !(upper && zero_page);
        end
    end

    // Address error trap in place of completion
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            addr_error_trap <= 1'b0;
        end
        else
        begin
            addr_error_trap <= req_valid && upper && zero_page;
        end
    end

    // Direction follows the request every cycle
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ext_write <= 1'b0;
        end
        else
        begin
            ext_write <= req_write;
        end
    end

    // Extended address, page value above the window offset
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ext_addr <= '0;
        end
        else if (upper)
        begin
            ext_addr <= {sel_page, effective_addr[OFFSET_W-1:0]};
        end
        else
        begin
            ext_addr <= {PAGE_ZERO, effective_addr[OFFSET_W-1:0]};
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // All checks sample on clk; all but reset_page_a rest during reset
    low_direct_a: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && !upper |=> ext_valid && !addr_error_trap
        && ext_addr[OFFSET_W-1:0] == $past(effective_addr[OFFSET_W-1:0]))
        else $error("lower address not passed directly");

    low_page0_a: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && !upper |=> ext_addr[EXT_W-1:OFFSET_W] == PAGE_ZERO)
        else $error("lower address not on page zero");

    no_upper0_a: assert property (@(posedge clk) disable iff (!rstn)
        ext_valid && $past(upper) |-> ext_addr[EXT_W-1:OFFSET_W] != PAGE_ZERO)
        else $error("page zero reached through upper window");

    reset_page_a: assert property (@(posedge clk)
        !rstn |=> read_page_select == PAGE_RESET
        && write_page_select == PAGE_RESET)
        else $error("page registers not one after reset");

    zero_trap_a: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && upper && zero_page |=> addr_error_trap && !ext_valid)
        else $error("zero page access did not trap");

    clear_ignored_a: assert property (@(posedge clk) disable iff (!rstn)
        page_wr_en && page_wr_data == PAGE_ZERO |=>
        $stable(read_page_select) && $stable(write_page_select))
        else $error("zero write changed a page register");

    upper_map_a: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && upper && !zero_page |=> ext_valid
        && ext_addr == {$past(sel_page), $past(effective_addr[OFFSET_W-1:0])})
        else $error("upper window address wrong");

    page1_map_a: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && upper && sel_page == PAGE_ONE |=>
        ext_addr >= PAGE1_BASE && ext_addr <= PAGE1_TOP)
        else $error("page one outside its range");

    page2_map_a: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && upper && sel_page == PAGE_TWO |=>
        ext_addr >= PAGE2_BASE && ext_addr <= PAGE2_TOP)
        else $error("page two outside its range");

    read_page_a: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && upper && !req_write && read_page_select != PAGE_ZERO
        |=> ext_addr[EXT_W-1:OFFSET_W] == $past(read_page_select)
        && !ext_write)
        else $error("read did not use read page");

    write_page_a: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && upper && req_write && write_page_select != PAGE_ZERO
        |=> ext_addr[EXT_W-1:OFFSET_W] == $past(write_page_select)
        && ext_write)
        else $error("write did not use write page");

    other_pages_a: assert property (@(posedge clk) disable iff (!rstn)
        ext_valid && ext_addr[EXT_W-1:OFFSET_W] != PAGE_ZERO |-> $past(upper))
        else $error("nonzero page reached without upper window");

    write_dir_a: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> ext_write == $past(req_write))
        else $error("access direction not carried through");

    idle_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
        !req_valid |=> !ext_valid && !addr_error_trap)
        else $error("answer without a request");

    trap_excl_a: assert property (@(posedge clk) disable iff (!rstn)
        addr_error_trap |-> !ext_valid)
        else $error("trapped access also completed");

    nonzero_page_a: assert property (@(posedge clk) disable iff (!rstn)
        read_page_select != PAGE_ZERO && write_page_select != PAGE_ZERO)
        else $error("a page register holds page zero");

    read_load_a: assert property (@(posedge clk) disable iff (!rstn)
        page_wr_en && !page_wr_sel && page_wr_data != PAGE_ZERO
        |=> read_page_select == $past(page_wr_data))
        else $error("read page write did not land");

    write_load_a: assert property (@(posedge clk) disable iff (!rstn)
        page_wr_en && page_wr_sel && page_wr_data != PAGE_ZERO
        |=> write_page_select == $past(page_wr_data))
        else $error("write page write did not land");

    page_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        !page_wr_en |=>
        $stable(read_page_select) && $stable(write_page_select))
        else $error("page register changed without a write");
endmodule
`default_nettype wire

// ### core/page_reg_if.sv
// Purpose: Write port and value of one data page select register
// Assumes: Single clock domain
// Notes: Owner holds the value, user steers the writes
`timescale 1ns/100ps
`default_nettype none
interface page_reg_if;
    import ext_space_pkg::*;
    logic wr_en;
    logic [PAGE_W-1:0] wr_data;
    logic [PAGE_W-1:0] page;
    modport owner (input wr_en, input wr_data, output page);
    modport user (output wr_en, output wr_data, input page);
endinterface
`default_nettype wire

// ### core/page_register.sv
// Purpose: One data page select register
// Assumes: Synchronous active-low reset
// Notes: Writes of zero are dropped so page zero never enters the window
`timescale 1ns/100ps
`default_nettype none
module page_register
    import ext_space_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    page_reg_if.owner port
);
    // Page value, reset to page one, zero writes ignored
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            port.page <= PAGE_RESET;
        end
        else if (port.wr_en && (port.wr_data != PAGE_ZERO))
        begin
            port.page <= port.wr_data;
        end
    end
endmodule
`default_nettype wire

// ### dv/cpu_agu_model.sv
// Purpose: Load/store address source standing in for the CPU core
// Assumes: One access or page write at a time, called by the bench
// Notes: Requests change 1 ns after a rising edge, held one edge
`timescale 1ns/100ps
`default_nettype none
module cpu_agu_model
    import ext_space_pkg::*;
(
    input wire logic clk,
    output logic req_valid,
    output logic req_write,
    output logic [BASE_W-1:0] effective_addr,
    output logic page_wr_en,
    output logic page_wr_sel,
    output logic [PAGE_W-1:0] page_wr_data
);
    // Idle values at time zero
    initial
    begin
        {req_valid, req_write, page_wr_en, page_wr_sel} = 4'h0;
        effective_addr = 16'h0000;
        page_wr_data = 9'h000;
    end
    // One access; the address is scrambled once the request is gone
    task automatic access(input logic wr, input logic [BASE_W-1:0] addr);
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req_write = wr;
        effective_addr = addr;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        effective_addr = ~addr;
    endtask
    // One page register write strobe
    task automatic page_write(input logic sel, input logic [PAGE_W-1:0] d);
        @(posedge clk);
        #1;
        page_wr_en = 1'b1;
        page_wr_sel = sel;
        page_wr_data = d;
        @(posedge clk);
        #1;
        page_wr_en = 1'b0;
        page_wr_data = ~d;
    endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
// Purpose: Self-checking bench for the extended data space paging block
// Assumes: 100 MHz clock, synchronous active-low reset
// Notes: Ends through the results task only
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ext_space_pkg::*;
    logic clk, rstn, req_valid, req_write, page_wr_en, page_wr_sel;
    logic [BASE_W-1:0] effective_addr;
    logic [PAGE_W-1:0] page_wr_data, read_page_select, write_page_select;
    logic ext_valid, ext_write, addr_error_trap;
    logic [EXT_W-1:0] ext_addr;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    // ********************************
    // Clock, reset and instances
    // ********************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    cpu_agu_model u_cpu (.clk(clk), .req_valid(req_valid),
        .req_write(req_write), .effective_addr(effective_addr),
        .page_wr_en(page_wr_en), .page_wr_sel(page_wr_sel),
        .page_wr_data(page_wr_data));
    extended_data_space_paging u_dut (.clk(clk), .rstn(rstn),
        .req_valid(req_valid), .req_write(req_write),
        .effective_addr(effective_addr), .page_wr_en(page_wr_en),
        .page_wr_sel(page_wr_sel), .page_wr_data(page_wr_data),
        .ext_valid(ext_valid), .ext_write(ext_write), .ext_addr(ext_addr),
        .addr_error_trap(addr_error_trap),
        .read_page_select(read_page_select),
        .write_page_select(write_page_select));
    // ********************************
    // Checking helpers
    // ********************************
    task automatic check(input string what, input logic [EXT_W-1:0] exp,
                         input logic [EXT_W-1:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One access, then its one-cycle answer
    task automatic acc(input logic wr, input logic [BASE_W-1:0] addr,
                       input logic [EXT_W-1:0] exp);
        u_cpu.access(wr, addr);
        check("ext_valid", 24'h000001, {23'h000000, ext_valid});
        check("trap", 24'h000000, {23'h000000, addr_error_trap});
        check("ext_write", {23'h000000, wr}, {23'h000000, ext_write});
        check("ext_addr", exp, ext_addr);
    endtask
    // Page values, and no answer while no request was taken
    task automatic pages(input logic [PAGE_W-1:0] rd, wr);
        check("read page", EXT_W'(rd), EXT_W'(read_page_select));
        check("write page", EXT_W'(wr), EXT_W'(write_page_select));
        check("idle valid", 24'h000000, {23'h000000, ext_valid});
        check("idle trap", 24'h000000, {23'h000000, addr_error_trap});
    endtask
    task automatic results;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ********************************
    // Scenarios
    // ********************************
    task automatic test_page_one;
        acc(1'b0, 16'h8004, PAGE1_BASE + 24'h000004);
        acc(1'b1, 16'hFFFF, PAGE1_TOP);
        acc(1'b0, 16'h8000, PAGE1_BASE);
    endtask
    task automatic test_zero_write;
        u_cpu.page_write(1'b0, PAGE_ZERO);
        u_cpu.page_write(1'b1, PAGE_ZERO);
        pages(PAGE_ONE, PAGE_ONE);
        acc(1'b1, 16'h8010, 24'h008010);
    endtask
    task automatic test_split_pages;
        u_cpu.page_write(1'b1, PAGE_TWO);
        pages(PAGE_ONE, PAGE_TWO);
        acc(1'b1, 16'hFFFF, PAGE2_TOP);
        acc(1'b0, 16'hFFFF, PAGE1_TOP);
        acc(1'b1, 16'h8000, PAGE2_BASE);
        u_cpu.page_write(1'b0, 9'h1FF);
        acc(1'b0, 16'h8001, 24'hFF8001);
    endtask
    task automatic test_lower;
        acc(1'b0, 16'h1234, 24'h001234);
        acc(1'b1, 16'h7FFF, 24'h007FFF);
        acc(1'b0, 16'h0000, 24'h000000);
    endtask
    // Reset in mid-run brings both pages back to one
    task automatic test_reset;
        @(posedge clk);
        #1;
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        pages(PAGE_RESET, PAGE_RESET);
        acc(1'b1, 16'h8000, PAGE1_BASE);
    endtask
    // Cycle ceiling against a hang
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            n_errors++;
            results;
        end
    end
    initial
    begin
        rstn = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        pages(PAGE_RESET, PAGE_RESET);
        test_page_one;
        test_zero_write;
        test_split_pages;
        test_lower;
        test_reset;
        results;
    end
endmodule
`default_nettype wire
